// [hw/fsr_pkg.sv]
/*
 * Constants, field layouts and carrier types for the fault status readout
 * block of the serial register interface.
 * Assumes two importers: fsr_top, clocked by sys_clk and the serial clock, and the bench.
 */
package fsr_pkg;

   // ****************************************************************
   // Frame layout
   // ****************************************************************
   localparam int unsigned ADDR_W     = 5;
   localparam int unsigned DATA_W     = 10;
   localparam int unsigned FRAME_BITS = 16;
   localparam logic [4:0]  CNT_FULL   = 5'h10;
   localparam logic [4:0]  CNT_SAT    = 5'h11;
   localparam logic [4:0]  CNT_ADDR   = 5'h04;
   localparam logic [4:0]  CNT_WR     = 5'h05;
   localparam logic [3:0]  FALL_LAST  = 4'hf;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [4:0] ADDR_SYSTEM = 5'h19;
   localparam logic [4:0] ADDR_MASK   = 5'h1c;
   localparam logic [4:0] ADDR_RBSEL  = 5'h1d;
   localparam logic [4:0] ADDR_DEMAND = 5'h1e;
   localparam logic [4:0] ADDR_MEAS   = 5'h1f;

   // ****************************************************************
   // Reset values and field positions
   // ****************************************************************
   localparam logic [9:0] MASK_RST   = 10'h100;
   localparam logic [9:0] SYSTEM_RST = 10'h140;
   localparam int unsigned DSR_BIT    = 6;
   localparam int unsigned MASK_BU    = 1;
   localparam int unsigned MASK_VO    = 0;
   localparam logic [2:0] RBS_DIAG   = 3'h0;

   typedef logic [9:0]        fsr_word_t;
   typedef fsr_word_t [31:0]  fsr_bank_t;
   typedef fsr_word_t [7:1]   fsr_meas_t;

   // Fault monitor inputs from the analog diagnostics
   typedef struct packed {
      logic       vpu;         // Programming supply undervoltage
      logic       cli;         // Current control active, live state
      logic [6:0] mon;         // Monitor faults, status bits 9..3
      logic [2:0] boot;        // Bootstrap undervoltage, phase A,B,C
      logic [5:0] drain;       // Drain-source overvoltage, AH..CL
      logic       speed_over;  // Speed above maximum reference
      logic       nvm_fail;    // User values not loaded
   } fsr_fault_t;

   // Status word bits 15..1
   typedef struct packed {
      logic       any_fault_summary;
      logic       por;
      logic       transfer_error_flag;
      logic       vpu;
      logic       cli;
      logic       rsvd;
      logic [6:0] mon;
      logic       bootstrap_undervolt_summary;
      logic       drain_excess_summary;
   } fsr_status_t;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        strb_prev;
      logic        clr;
      logic        por;
      logic        se;
      logic        vpu;
      logic [6:0]  mon;
      logic [2:0]  boot;
      logic [5:0]  drain;
      fsr_bank_t   bank;
      fsr_status_t snap_st;
      fsr_word_t   snap_rb;
   } fsr_sys_t;

   typedef struct packed {
      logic [15:0] rx;
      logic [4:0]  cnt;
      logic [4:0]  addr;
      logic        wr;
   } fsr_ser_t;

endpackage

// [hw/fsr_top.sv]
/*
 * Status, diagnostic and configuration register logic behind the
 * strobe-framed serial link: latches faults, formats the output word,
 * clears flags on valid reads.
 * Assumes the master holds the strobe high long enough for three sys_clk
 * edges between frames and low for three before its first clock edge.
 */
// How it works
// - Top five status bits always shifted first
// - Measurement address returns readback then parity
// - Sixth output bit zero for other addresses
// - Write flag stores data, returns low status
// - Read returns register contents plus parity
// - Status layout: critical, current control, monitors
// - Bootstrap fault sets summary and phase bit
// - Drain fault sets summary and switch bit
// - Diagnostic top bit shows speed overrange
// - Overrange bit live, never sets status
// - Fault flags latch until a clearing read or reset
// - Clearing keeps flags of present faults
// - Status flags clear only on status read
// - Summary bits follow diagnostic flags
// - Diagnostic flags clear only on diagnostic read
// - Read-reset disable bit keeps contents
// - Bit 15 ORs all status fault bits
// - Strobe low drives output, high releases
// - Clockless poll frame raises no error
// - Power-on sets summary and power-on bit
// - Bit 13 meaning depends on power-on bit
// - Mask bit fully disables its diagnostic
// - Odd parity regenerated every frame
// - Output msb first, advance on falling edge
`timescale 1ns/1ps

module fsr_top
   import fsr_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               ser_clk,
   input  wire logic               frame_strobe_n,
   input  wire logic               sdi,
   output logic                    sdo_o,
   output logic                    sdo_oe,
   input  wire fsr_pkg::fsr_fault_t flt,
   input  wire fsr_pkg::fsr_meas_t  meas,
   output fsr_pkg::fsr_bank_t      cfg_bank,
   output fsr_pkg::fsr_status_t    status_word
);
   import fsr_pkg::*;

   fsr_sys_t    q;
   fsr_sys_t    d;
   fsr_ser_t    sq;
   fsr_ser_t    sd;
   logic [3:0]  fall_q;
   fsr_status_t st;
   logic        ser_clr;
   logic        end_evt;
   logic        frame_ok;
   logic        silent;
   logic        bad;
   logic        good;
   logic        is_meas;
   logic        is_wr;
   logic        st_clr;
   logic        dg_clr;
   logic        dsr;
   fsr_word_t   mask;
   logic [15:0] tx;

   function automatic logic wr_frame(input logic [4:0] a, input logic w);
      wr_frame = w | (a == ADDR_DEMAND);
   endfunction

   // ****************************************************************
   // Status word assembly
   // ****************************************************************
   always_comb begin
      st      = '0;
      st.por  = q.por;
      st.transfer_error_flag = q.se;
      st.vpu  = q.vpu;
      st.cli  = flt.cli;
      st.mon  = q.mon;
      st.bootstrap_undervolt_summary = |q.boot;
      st.drain_excess_summary        = |q.drain;
      st.any_fault_summary = q.por | q.se | q.vpu | (|q.mon) |
                             (|q.boot) | (|q.drain);
   end

   assign status_word = st;
   assign cfg_bank    = q.bank;

   // ****************************************************************
   // Frame end decode
   // ****************************************************************
   always_comb begin
      end_evt  = q.sync2 & ~q.strb_prev;
      frame_ok = (sq.cnt == CNT_FULL) & (^sq.rx);
      silent   = (sq.cnt == '0);
      good     = end_evt & frame_ok;
      bad      = end_evt & ~frame_ok & ~silent;
      is_meas  = (sq.rx[15:11] == ADDR_MEAS);
      is_wr    = wr_frame(sq.rx[15:11], sq.rx[10]);
      mask     = q.bank[ADDR_MASK];
      dsr      = q.bank[ADDR_RBSEL][DSR_BIT];
      st_clr   = good & ~is_meas & is_wr & ~dsr;
      dg_clr   = good & is_meas & ~dsr &
                 (q.bank[ADDR_RBSEL][2:0] == RBS_DIAG);
   end

   // ****************************************************************
   // System clock state
   // ****************************************************************
   always_comb begin
      d           = q;
      d.sync1     = frame_strobe_n;
      d.sync2     = q.sync1;
      d.strb_prev = q.sync2;
      if (!q.sync2) begin
         d.clr = 1'b0;
      end else if (end_evt) begin
         d.clr = 1'b1;
      end
      if (good && !is_meas && is_wr) begin
         if (sq.rx[15:11] == ADDR_DEMAND) begin
            d.bank[sq.rx[15:11]] = sq.rx[10:1];
         end else begin
            d.bank[sq.rx[15:11]] = {1'b0, sq.rx[9:1]};
         end
      end
      // Set wins over clear; present faults stay set
      d.mon   = (st_clr ? '0 : q.mon) |
                (flt.mon & ~mask[8:2]);
      d.vpu   = (st_clr ? 1'b0 : q.vpu) | flt.vpu;
      d.boot  = (dg_clr ? '0 : q.boot) |
                (flt.boot & {3{~mask[MASK_BU]}});
      d.drain = (dg_clr ? '0 : q.drain) |
                (flt.drain & {6{~mask[MASK_VO]}});
      d.por   = q.por & ~st_clr;
      d.se    = (st_clr ? 1'b0 : q.se) | bad |
                (q.por & ~st_clr & flt.nvm_fail);
      // Snapshot follows while idle and freezes for the frame
      if (q.sync2) begin
         d.snap_st = st;
         if (q.bank[ADDR_RBSEL][2:0] == RBS_DIAG) begin
            d.snap_rb = {flt.speed_over, q.boot, q.drain};
         end else begin
            d.snap_rb = meas[q.bank[ADDR_RBSEL][2:0]];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q                   <= '0;
         q.sync1             <= 1'b1;
         q.sync2             <= 1'b1;
         q.strb_prev         <= 1'b1;
         q.clr               <= 1'b1;
         q.por               <= 1'b1;
         q.bank[ADDR_MASK]   <= MASK_RST;
         q.bank[ADDR_SYSTEM] <= SYSTEM_RST;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Serial clock side
   // ****************************************************************
   // Cleared between frames once the frame end has been taken
   assign ser_clr = q.clr & frame_strobe_n;

   always_comb begin
      sd = sq;
      if (!frame_strobe_n) begin
         sd.rx = {sq.rx[14:0], sdi};
         if (sq.cnt != CNT_SAT) begin
            sd.cnt = sq.cnt + 5'h01;
         end
         if (sq.cnt == CNT_ADDR) begin
            sd.addr = {sq.rx[3:0], sdi};
         end
         if (sq.cnt == CNT_WR) begin
            sd.wr = sdi;
         end
      end
   end

   always_ff @(posedge ser_clk or posedge ser_clr) begin
      if (ser_clr) begin
         sq <= '0;
      end else begin
         sq <= sd;
      end
   end

   always_ff @(negedge ser_clk or posedge ser_clr) begin
      if (ser_clr) begin
         fall_q <= '0;
      end else if (!frame_strobe_n && fall_q != FALL_LAST) begin
         fall_q <= fall_q + 4'h1;
      end
   end

   // ****************************************************************
   // Output word and pin
   // ****************************************************************
   always_comb begin
      tx        = '0;
      tx[15:11] = q.snap_st[14:10];
      if (sq.addr == ADDR_MEAS) begin
         tx[10:1] = q.snap_rb;
      end else if (wr_frame(sq.addr, sd.wr)) begin
         tx[10:1] = {1'b0, q.snap_st[8:0]};
      end else begin
         tx[10:1] = {1'b0, q.bank[sq.addr][8:0]};
      end
      tx[0] = ~^tx[15:1];
   end

   assign sdo_o  = tx[FALL_LAST - fall_q];
   assign sdo_oe = ~frame_strobe_n;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_por_set;
      @(posedge sys_clk) $past(rst) && !rst |->
         q.por && st.any_fault_summary && q.mon == '0;
   endproperty
   a_por_set: assert property (p_por_set)
      else $error("power-on flags wrong after reset");

   property p_ff_or;
      @(posedge sys_clk) disable iff (rst)
      st.any_fault_summary == (q.por | q.se | q.vpu | (|q.mon) |
                               st.bootstrap_undervolt_summary |
                               st.drain_excess_summary);
   endproperty
   a_ff_or: assert property (p_ff_or)
      else $error("summary bit not OR of fault bits");

   property p_mon_latch;
      @(posedge sys_clk) disable iff (rst)
      flt.mon[2] && !mask[4] |=> q.mon[2] ##1 q.mon[2] || $past(st_clr);
   endproperty
   a_mon_latch: assert property (p_mon_latch)
      else $error("present fault not latched");

   property p_mon_clear;
      @(posedge sys_clk) disable iff (rst)
      $fell(q.mon[2]) |-> $past(st_clr) && $past(!flt.mon[2]);
   endproperty
   a_mon_clear: assert property (p_mon_clear)
      else $error("status flag cleared without status read");

   property p_diag_clear;
      @(posedge sys_clk) disable iff (rst)
      $fell(st.drain_excess_summary) |-> $past(dg_clr);
   endproperty
   a_diag_clear: assert property (p_diag_clear)
      else $error("diagnostic flag cleared without diagnostic read");

   property p_mask;
      @(posedge sys_clk) disable iff (rst)
      mask[2] && !q.mon[0] |=> !q.mon[0];
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked diagnostic raised a flag");

   property p_bad_frame;
      @(posedge sys_clk) disable iff (rst)
      end_evt && sq.cnt != CNT_FULL && sq.cnt != '0 |=>
         q.se ##1 st.any_fault_summary;
   endproperty
   a_bad_frame: assert property (p_bad_frame)
      else $error("short frame did not flag transfer error");

   property p_silent;
      @(posedge sys_clk) disable iff (rst)
      end_evt && silent && !q.se && !q.por |=> !q.se;
   endproperty
   a_silent: assert property (p_silent)
      else $error("clockless poll flagged an error");

   property p_dsr_keep;
      @(posedge sys_clk) disable iff (rst)
      good && dsr && !is_meas && is_wr |=>
         (q.mon & $past(q.mon)) == $past(q.mon);
   endproperty
   a_dsr_keep: assert property (p_dsr_keep)
      else $error("read reset happened with disable bit set");

   property p_write;
      @(posedge sys_clk) disable iff (rst)
      good && !is_meas && sq.rx[10] && sq.rx[15:11] == ADDR_MASK |=>
         mask == {1'b0, $past(sq.rx[9:1])};
   endproperty
   a_write: assert property (p_write)
      else $error("written data not stored");

   property p_parity;
      @(negedge ser_clk) disable iff (frame_strobe_n)
      ^tx == 1'b1;
   endproperty
   a_parity: assert property (p_parity)
      else $error("output frame parity not odd");

   property p_first_bit;
      @(posedge sys_clk) disable iff (rst)
      !frame_strobe_n && !q.sync2 && fall_q == '0 |->
         sdo_oe && sdo_o == q.snap_st[14];
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first output bit is not the fault summary");

   property p_boot_set;
      @(posedge sys_clk) disable iff (rst)
      flt.boot != '0 && !mask[MASK_BU] |=> st.bootstrap_undervolt_summary &&
         (q.boot & $past(flt.boot)) == $past(flt.boot);
   endproperty
   a_boot_set: assert property (p_boot_set)
      else $error("bootstrap fault not latched with its phase");

   property p_drain_set;
      @(posedge sys_clk) disable iff (rst)
      flt.drain != '0 && !mask[MASK_VO] |=> st.drain_excess_summary &&
         (q.drain & $past(flt.drain)) == $past(flt.drain);
   endproperty
   a_drain_set: assert property (p_drain_set)
      else $error("drain fault not latched with its switch");

   property p_osr_live;
      @(posedge sys_clk) disable iff (rst)
      q.sync2 && q.bank[ADDR_RBSEL][2:0] == RBS_DIAG |=>
         q.snap_rb[9] == $past(flt.speed_over);
   endproperty
   a_osr_live: assert property (p_osr_live)
      else $error("speed overrange bit not tracking the monitor");

   c_write: cover property (@(posedge sys_clk) good && is_wr);
   c_diag:  cover property (@(posedge sys_clk) dg_clr && (|q.boot));
   c_bad:   cover property (@(posedge sys_clk) bad);
   c_poll:  cover property (@(posedge sys_clk) end_evt && silent);

endmodule

// [tb/fsr_master_model.sv]
/*
 * Serial bus master model for the fault status readout block.
 * Assumes sys_clk is running; strobe timing is counted in sys_clk edges, bit timing in fixed ns delays.
 */
`timescale 1ns/1ps

module fsr_master_model (
   input  wire logic sys_clk,
   output logic      ser_clk,
   output logic      frame_strobe_n,
   output logic      sdi,
   input  wire logic sdo_o,
   input  wire logic sdo_oe,
   output logic      oe_ok
);
   // ****************************************************************
   // Frame engine
   // ****************************************************************
   initial begin
      ser_clk        = 1'b0;
      frame_strobe_n = 1'b1;
      sdi            = 1'b0;
      oe_ok          = 1'b1;
   end

   // Link clock runs at 12 ns only inside the frame, held at hi before it, low after
   task automatic xfer(input logic [15:0] tx, input int n, input logic hi,
                       output logic [15:0] rx);
      int i;
      rx    = '0;
      oe_ok = 1'b1;
      @(posedge sys_clk);
      ser_clk = hi;
      #2 frame_strobe_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      for (i = 0; i < n; i++) begin
         // Write flag rides in bit 10, parity in bit 0
         sdi = (i < 16) ? tx[15-i] : 1'b0;
         #6;
         rx = {rx[14:0], sdo_o};
         if (sdo_oe !== 1'b1) begin
            oe_ok = 1'b0;
         end
         ser_clk = 1'b1;
         #6 ser_clk = 1'b0;
      end
      #3 frame_strobe_n = 1'b1;
      #3 ser_clk = 1'b0;
      // Released data line shows the inverse of its last level
      sdi = ~sdi;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

// [tb/test_fault_status_readout.sv]
/*
 * Self-checking bench for fsr_top: register frames, fault latching,
 * clearing, masking and transfer errors.
 * Assumes fsr_master_model as the serial master and the fsr_pkg layout.
 */
`timescale 1ns/1ps

module test_fault_status_readout;
   import fsr_pkg::*;
   logic        sys_clk;
   logic        rst;
   fsr_fault_t  flt;
   fsr_meas_t   meas;
   fsr_bank_t   cfg_bank;
   fsr_status_t status_word;
   wire logic   ser_clk, frame_strobe_n, sdi, sdo_o, sdo_oe, oe_ok;
   int          n_fail, tests_run, k;
   logic [15:0] rx;

   fsr_top fsr_top_i (
      .sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk),
      .frame_strobe_n(frame_strobe_n), .sdi(sdi), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .flt(flt), .meas(meas), .cfg_bank(cfg_bank),
      .status_word(status_word)
   );

   fsr_master_model fsr_master_model_i (
      .sys_clk(sys_clk), .ser_clk(ser_clk),
      .frame_strobe_n(frame_strobe_n), .sdi(sdi), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .oe_ok(oe_ok)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] mk(input logic [4:0] t,
                                      input logic [9:0] m);
      return {t, m, ~^{t, m}};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      @(negedge sys_clk);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic st(input logic [14:0] e);
      chk({1'b0, status_word}, {1'b0, e});
   endtask

   task automatic setf(input fsr_fault_t f);
      @(posedge sys_clk);
      flt <= f;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic fr(input logic [4:0] a, input logic w,
                     input logic [8:0] d, input logic [15:0] exp);
      logic [15:0] r;
      fsr_master_model_i.xfer({a, w, d, ~^{a, w, d}}, 16, 1'b0, r);
      chk(r, exp);
      chk({15'h0, sdo_oe}, 16'h0);
      chk({15'h0, oe_ok}, 16'h1);
   endtask

   task automatic final_report;
      $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Clock, watchdog and sequence
   // ****************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      final_report;
   end

   initial begin
      rst       = 1'b1;
      flt       = '0;
      meas      = '0;
      meas[3]   = 10'h2b5;
      n_fail    = 0;
      tests_run = 0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      st(15'h6000);
      chk({6'h0, cfg_bank[ADDR_MASK]}, {6'h0, MASK_RST});
      chk({15'h0, sdo_oe}, 16'h0);
      fr(ADDR_MASK, 1'b1, 9'h000, mk(5'h18, 10'h000));
      st(15'h0);
      chk({7'h0, cfg_bank[ADDR_MASK][8:0]}, 16'h0);
      fr(ADDR_SYSTEM, 1'b0, 9'h1ff,
         mk(5'h00, {1'b0, SYSTEM_RST[8:0]}));
      chk({6'h0, cfg_bank[ADDR_SYSTEM]}, {6'h0, SYSTEM_RST});
      // Monitor, bootstrap and drain faults, one monitor stays present
      setf({2'b01, 7'h0c, 3'b010, 6'h10, 2'b10});
      setf({2'b01, 7'h08, 9'h000, 2'b10});
      st({5'h11, 1'b0, 7'h0c,
          2'b11});
      fr(ADDR_DEMAND, 1'b1, 9'h000,
         mk(5'h11, {1'b0, 7'h0c, 2'b11}));
      st({5'h11, 1'b0, 7'h08, 2'b11});
      fr(ADDR_MEAS, 1'b0, 9'h000,
         mk(5'h11, 10'h290));
      st({5'h11, 1'b0, 7'h08, 2'b00});
      setf('0);
      fr(ADDR_MASK, 1'b1, 9'h004,
         mk(5'h10, {1'b0, 7'h08, 2'b00}));
      st(15'h0);
      // Bad parity, short frame, long frame
      for (k = 0; k < 3; k++) begin
         fsr_master_model_i.xfer({ADDR_MASK, 1'b1, 9'h1ff,
            (k == 0) ^ ~^{ADDR_MASK, 1'b1, 9'h1ff}},
            (k == 0) ? 16 : 13 + 2 * k, 1'b0, rx);
         st(15'h5000);
         chk({7'h0, cfg_bank[ADDR_MASK][8:0]}, 16'h004);
         fr(ADDR_DEMAND, 1'b1, 9'h000, mk(5'h14, 10'h000));
      end
      fsr_master_model_i.xfer(16'h0, 0, 1'b1, rx);
      st(15'h0);
      setf({2'b00, 7'h01, 11'h000});
      setf('0);
      st(15'h0);
      fr(ADDR_RBSEL, 1'b1, 9'h040, mk(5'h00, 10'h000));
      setf({2'b00, 7'h02, 11'h000});
      setf('0);
      fr(ADDR_DEMAND, 1'b1, 9'h000,
         mk(5'h10, {1'b0, 7'h02, 2'b00}));
      st({5'h10, 1'b0, 7'h02, 2'b00});
      fr(ADDR_RBSEL, 1'b1, 9'h043,
         mk(5'h10, {1'b0, 7'h02, 2'b00}));
      fr(ADDR_MEAS, 1'b0, 9'h000, mk(5'h10, meas[3]));
      final_report;
   end
endmodule
